// ==== pkg/mgp_regs.vh ====
// Register offsets, field positions and reset values of the general-purpose ports
`ifndef MGP_REGS_VH
`define MGP_REGS_VH
`define MGP_ADDR_W 8
`define MGP_WAKE_OUT_ADDR 8'hD0
`define MGP_WAKE_DIR_ADDR 8'hD1
`define MGP_WAKE_PIN_ADDR 8'hD2
`define MGP_MIX_OUT_ADDR 8'hD4
`define MGP_MIX_DIR_ADDR 8'hD5
`define MGP_MIX_PIN_ADDR 8'hD6
`define MGP_OUTP_ADDR 8'hDC
`define MGP_WAKEUP_ENABLE_REGISTER_ADDR 8'hC9
`define MGP_CTRL2_ADDR 8'hCC
`define MGP_CTRL1_ADDR 8'hEE
`define MGP_PSW_ADDR 8'hEF
`define MGP_MIX_BIDIR_MASK 8'h3F
`define MGP_HALT_BIT 7
`define MGP_OUTP_RESET 4'hF
`define MGP_LATCH_RESET 8'h00
// Alternate-function enable bits inside the control registers
`define MGP_CTRL2_CMP_EN 0
`define MGP_CTRL2_CMP_OE 1
`define MGP_CTRL2_MOD_EN 2
`define MGP_CTRL1_TMR_OE 0
`define MGP_CTRL1_SER_EN 1
`define MGP_CTRL1_SCK_MST 2
`define MGP_PSW_EXT_IE 0
`endif

// ==== logic/mgp_sync2.v ====
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module mgp_sync2 #(
  parameter W = 8
) (
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // mgp_sync2

// ==== logic/mgp_pin_cell.v ====
// Bidirectional pin decode with optional alternate-function override
`timescale 1ns/100ps
module mgp_pin_cell #(
  parameter W = 8
) (
  input wire [W-1:0] dir,
  input wire [W-1:0] dat,
  input wire [W-1:0] alt_oe,
  input wire [W-1:0] alt_val,
  output wire [W-1:0] pin_o,
  output wire [W-1:0] pin_oe,
  output wire [W-1:0] pull_en
);
  // Alternate output takes the pin as a push-pull driver
  assign pin_oe = dir | alt_oe;
  assign pin_o = (alt_oe & alt_val) | (~alt_oe & dat);
  assign pull_en = ~dir & ~alt_oe & dat;
endmodule // mgp_pin_cell

// ==== logic/mgp_ports.v ====
// General-purpose port block: wake port, mixed port, output port, input port
//
// Function
// - config/data pair selects pin mode
// - wake port registers at D0, D1, D2
// - mixed port registers at D4, D5, D6
// - mixed bits 0-5 bidirectional, 6-7 input
// - input-only config bits ignore writes
// - input-only config bits read zero
// - writing one to mixed data7 halts
// - halt holds clock input high with crystal or RC option
// - wake alternates enabled at C9, CC
// - mixed port serial, timer, interrupt alternates
// - interrupt from EF, timer/serial from EE
// - mixed pin7 crystal output or input
// - output port at DC, reset ones
// - 4-bit input-only port, no drivers
`timescale 1ns/100ps
`include "mgp_regs.vh"
module mgp_ports #(
  parameter CRYSTAL_OPT = 1'b0,
  parameter RC_OPT = 1'b0
) (
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  input wire [7:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  output wire bus_hit,
  input wire [7:0] wake_pin_i,
  output wire [7:0] wake_pin_o,
  output wire [7:0] wake_pin_oe,
  output wire [7:0] wake_pull_en,
  input wire [7:0] mix_pin_i,
  output wire [5:0] mix_pin_o,
  output wire [5:0] mix_pin_oe,
  output wire [5:0] mix_pull_en,
  output wire [3:0] out_port_o,
  input wire [3:0] in_port_i,
  input wire osc_clk,
  output wire clock_input_hold,
  output wire crystal_clock_output,
  output wire crystal_clock_output_oe,
  output reg halt_r,
  input wire halt_restart,
  output wire [7:0] multi_input_wakeup,
  output wire [7:0] wake_levels,
  output wire comparator_positive_input,
  output wire comparator_negative_input,
  input wire comparator_result,
  input wire modulator_value,
  output wire external_interrupt_pin,
  output wire external_interrupt_en,
  output wire timer_pin_in,
  input wire timer_out,
  output wire serial_data_in,
  input wire serial_data_out,
  input wire serial_clock_out,
  output wire serial_clock_in
);
  reg [7:0] wake_out_r;
  reg [7:0] wake_dir_r;
  reg [7:0] mix_out_r;
  reg [7:0] mix_dir_r;
  reg [3:0] outp_r;
  reg [7:0] wakeup_enable_register_r;
  reg [7:0] ctrl2_r;
  reg [7:0] ctrl1_r;
  reg [7:0] psw_r;
  wire [7:0] wake_sync;
  wire [7:0] mix_sync;
  wire [3:0] in_sync;
  wire [7:0] wake_alt_oe;
  wire [7:0] wake_alt_val;
  wire [5:0] mix_alt_oe;
  wire [5:0] mix_alt_val;
  wire wr;

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign wr = ce & bus_wr;

  mgp_sync2 #(.W(8)) u_wake_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .d(wake_pin_i),
    .q(wake_sync)
  );
  mgp_sync2 #(.W(8)) u_mix_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .d(mix_pin_i),
    .q(mix_sync)
  );
  mgp_sync2 #(.W(4)) u_in_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .d(in_port_i),
    .q(in_sync)
  );

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      wake_out_r <= `MGP_LATCH_RESET;
      wake_dir_r <= `MGP_LATCH_RESET;
      mix_out_r <= `MGP_LATCH_RESET;
      mix_dir_r <= `MGP_LATCH_RESET;
      outp_r <= `MGP_OUTP_RESET;
      wakeup_enable_register_r <= 8'h00;
      ctrl2_r <= 8'h00;
      ctrl1_r <= 8'h00;
      psw_r <= 8'h00;
    end else if (wr) begin
      if (hit(bus_addr, `MGP_WAKE_OUT_ADDR)) begin
        wake_out_r <= bus_wdata;
      end
      if (hit(bus_addr, `MGP_WAKE_DIR_ADDR)) begin
        wake_dir_r <= bus_wdata;
      end
      if (hit(bus_addr, `MGP_MIX_OUT_ADDR)) begin
        mix_out_r <= bus_wdata;
      end
      if (hit(bus_addr, `MGP_MIX_DIR_ADDR)) begin
        // Upper two bits can never become outputs
        mix_dir_r <= bus_wdata & `MGP_MIX_BIDIR_MASK;
      end
      if (hit(bus_addr, `MGP_OUTP_ADDR)) begin
        outp_r <= bus_wdata[3:0];
      end
      if (hit(bus_addr, `MGP_WAKEUP_ENABLE_REGISTER_ADDR)) begin
        wakeup_enable_register_r <= bus_wdata;
      end
      if (hit(bus_addr, `MGP_CTRL2_ADDR)) begin
        ctrl2_r <= bus_wdata;
      end
      if (hit(bus_addr, `MGP_CTRL1_ADDR)) begin
        ctrl1_r <= bus_wdata;
      end
      if (hit(bus_addr, `MGP_PSW_ADDR)) begin
        psw_r <= bus_wdata;
      end
    end
  end

  // Halt: set by the data write, cleared by restart pin (without crystal option) or reset
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      halt_r <= 1'b0;
    end else if (ce) begin
      if (bus_wr && hit(bus_addr, `MGP_MIX_OUT_ADDR) && bus_wdata[`MGP_HALT_BIT]) begin
        halt_r <= 1'b1;
      end else if (halt_r && halt_restart && !CRYSTAL_OPT) begin
        halt_r <= 1'b0;
      end
    end
  end

  assign clock_input_hold = halt_r & (CRYSTAL_OPT | RC_OPT);
  // Crystal output parks high along with the clock input during halt
  assign crystal_clock_output = halt_r | osc_clk;
  assign crystal_clock_output_oe = CRYSTAL_OPT;

  // Wake port alternates
  assign multi_input_wakeup = wake_sync & wakeup_enable_register_r;
  assign wake_levels = wake_sync;
  assign comparator_positive_input = wake_sync[2];
  assign comparator_negative_input = wake_sync[1];
  assign wake_alt_oe = {ctrl2_r[`MGP_CTRL2_MOD_EN], 6'b00_0000,
                        ctrl2_r[`MGP_CTRL2_CMP_EN] & ctrl2_r[`MGP_CTRL2_CMP_OE]};
  assign wake_alt_val = {modulator_value, 6'b00_0000, comparator_result};

  mgp_pin_cell #(.W(8)) u_wake_cell (
    .dir(wake_dir_r),
    .dat(wake_out_r),
    .alt_oe(wake_alt_oe),
    .alt_val(wake_alt_val),
    .pin_o(wake_pin_o),
    .pin_oe(wake_pin_oe),
    .pull_en(wake_pull_en)
  );

  // Mixed port alternates
  assign mix_alt_oe = {ctrl1_r[`MGP_CTRL1_SER_EN] & ctrl1_r[`MGP_CTRL1_SCK_MST],
                       ctrl1_r[`MGP_CTRL1_SER_EN], ctrl1_r[`MGP_CTRL1_TMR_OE],
                       3'b000};
  assign mix_alt_val = {serial_clock_out, serial_data_out, timer_out, 3'b000};

  mgp_pin_cell #(.W(6)) u_mix_cell (
    .dir(mix_dir_r[5:0]),
    .dat(mix_out_r[5:0]),
    .alt_oe(mix_alt_oe),
    .alt_val(mix_alt_val),
    .pin_o(mix_pin_o),
    .pin_oe(mix_pin_oe),
    .pull_en(mix_pull_en)
  );

  assign serial_data_in = mix_sync[6];
  assign serial_clock_in = mix_sync[5];
  assign timer_pin_in = mix_sync[3];
  // Pulse widths below one cycle may be missed by the synchroniser
  assign external_interrupt_pin = mix_sync[0];
  assign external_interrupt_en = psw_r[`MGP_PSW_EXT_IE];

  assign out_port_o = outp_r;

  assign bus_hit = hit(bus_addr, `MGP_WAKE_OUT_ADDR) | hit(bus_addr, `MGP_WAKE_DIR_ADDR) |
                   hit(bus_addr, `MGP_WAKE_PIN_ADDR) | hit(bus_addr, `MGP_MIX_OUT_ADDR) |
                   hit(bus_addr, `MGP_MIX_DIR_ADDR) | hit(bus_addr, `MGP_MIX_PIN_ADDR) |
                   hit(bus_addr, `MGP_OUTP_ADDR) | hit(bus_addr, `MGP_WAKEUP_ENABLE_REGISTER_ADDR) |
                   hit(bus_addr, `MGP_CTRL2_ADDR) | hit(bus_addr, `MGP_CTRL1_ADDR) |
                   hit(bus_addr, `MGP_PSW_ADDR);

  // Registered read data, one cycle after the strobe
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_rdata <= 8'h00;
    end else if (ce && bus_rd) begin
      case (bus_addr)
        `MGP_WAKE_OUT_ADDR: bus_rdata <= wake_out_r;
        `MGP_WAKE_DIR_ADDR: bus_rdata <= wake_dir_r;
        `MGP_WAKE_PIN_ADDR: bus_rdata <= wake_sync;
        `MGP_MIX_OUT_ADDR: bus_rdata <= mix_out_r;
        `MGP_MIX_DIR_ADDR: bus_rdata <= mix_dir_r & `MGP_MIX_BIDIR_MASK;
        `MGP_MIX_PIN_ADDR: bus_rdata <= mix_sync;
        `MGP_OUTP_ADDR: bus_rdata <= {4'h0, outp_r};
        `MGP_WAKEUP_ENABLE_REGISTER_ADDR: bus_rdata <= wakeup_enable_register_r;
        `MGP_CTRL2_ADDR: bus_rdata <= ctrl2_r;
        `MGP_CTRL1_ADDR: bus_rdata <= ctrl1_r;
        `MGP_PSW_ADDR: bus_rdata <= psw_r;
        // Input-only port has no address of its own here; sits nowhere else
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  // Input port is synchronised but never read over the bus or driven
  wire [3:0] in_levels_unused;
  assign in_levels_unused = in_sync;
endmodule // mgp_ports

// ==== tb/mgp_ports_checker.sv ====
// Port-level assertions for the general-purpose port block
`timescale 1ns/100ps
module mgp_ports_checker #(
  parameter CRYSTAL_OPT = 1'b0,
  parameter RC_OPT = 1'b0
) (
  input wire clk_sys, input wire rst_b, input wire ce, input wire [7:0] bus_addr,
  input wire bus_wr, input wire bus_rd, input wire [7:0] bus_wdata, input wire [7:0] bus_rdata,
  input wire [7:0] wake_pin_oe, input wire [7:0] wake_pull_en, input wire [5:0] mix_pin_oe,
  input wire [3:0] out_port_o, input wire clock_input_hold, input wire halt_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire wr_go = ce && bus_wr;
  out_reset_a: assert property ($rose(rst_b) |-> out_port_o == 4'hF)
    else $error("output port not preset");
  latch_clear_a: assert property ($rose(rst_b) |-> (wake_pin_oe | wake_pull_en) == 8'h00 &&
    mix_pin_oe == 6'h00) else $error("latches not cleared");
  wake_dir_a: assert property (wr_go && bus_addr == 8'hD1 |=>
    wake_pin_oe[6:1] == $past(bus_wdata[6:1])) else $error("wake drive wrong");
  mix_dir_a: assert property (wr_go && bus_addr == 8'hD5 |=>
    mix_pin_oe[2:1] == $past(bus_wdata[2:1])) else $error("mixed drive wrong");
  dir_read_a: assert property (ce && bus_rd && bus_addr == 8'hD5 |=>
    bus_rdata[7:6] == 2'b00) else $error("input-only config read nonzero");
  halt_set_a: assert property (wr_go && bus_addr == 8'hD4 && bus_wdata[7] |=> halt_r)
    else $error("halt not entered");
  clk_hold_a: assert property (clock_input_hold == (halt_r && (CRYSTAL_OPT || RC_OPT)))
    else $error("clock hold wrong");
  pin_write_a: assert property (wr_go && bus_addr == 8'hD2 |=>
    $stable(wake_pin_oe) && $stable(wake_pull_en)) else $error("pin-level write had effect");
endmodule // mgp_ports_checker

bind mgp_ports mgp_ports_checker #(.CRYSTAL_OPT(CRYSTAL_OPT), .RC_OPT(RC_OPT)) chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .bus_addr(bus_addr), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .wake_pin_oe(wake_pin_oe),
  .wake_pull_en(wake_pull_en), .mix_pin_oe(mix_pin_oe), .out_port_o(out_port_o),
  .clock_input_hold(clock_input_hold), .halt_r(halt_r));

// ==== tb/mgp_board.sv ====
// Board model: resolves pin levels from device drive, pull-ups and outside drivers
`timescale 1ns/100ps
module mgp_board (
  input wire clk_sys, input wire [7:0] wake_pin_o, input wire [7:0] wake_pin_oe,
  input wire [7:0] wake_pull_en, input wire [5:0] mix_pin_o, input wire [5:0] mix_pin_oe,
  input wire [5:0] mix_pull_en, input wire [7:0] ext_w, input wire [7:0] ext_we,
  input wire [7:0] ext_m, input wire [7:0] ext_me,
  output wire [7:0] wake_pin_i, output wire [7:0] mix_pin_i
);
  reg flt_r = 1'b0;
  wire [7:0] m_oe = {2'b00, mix_pin_oe};
  // Undriven lines wander so a stale level never passes for a driven one
  always @(posedge clk_sys) flt_r <= ~flt_r;
  assign wake_pin_i = wake_pin_oe & wake_pin_o | ~wake_pin_oe &
    (ext_we & ext_w | ~ext_we & (wake_pull_en | {8{flt_r}}));
  assign mix_pin_i = m_oe & {2'b00, mix_pin_o} | ~m_oe &
    (ext_me & ext_m | ~ext_me & ({2'b00, mix_pull_en} | {8{flt_r}}));
endmodule // mgp_board

// ==== tb/mgp_ports_test.sv ====
// Directed bench for the general-purpose port block
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mgp_ports_test;
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg ce = 1'b1;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg [7:0] bus_addr = 8'h00;
  reg [7:0] bus_wdata = 8'h00;
  reg [7:0] ext_w = 8'h00;
  reg [7:0] ext_we = 8'h00;
  reg [7:0] ext_m = 8'h00;
  reg [7:0] ext_me = 8'h00;
  reg [5:0] alt_in = 6'h00;
  int fails = 0;
  int compares = 0;
  wire [7:0] bus_rdata, wake_pin_i, wake_pin_o, wake_pin_oe, wake_pull_en, mix_pin_i, wake_mw;
  wire [5:0] mix_pin_o, mix_pin_oe, mix_pull_en;
  wire [3:0] out_port_o;
  wire [2:0] mix_alt;
  wire [1:0] cmp_in;
  wire clock_input_hold, xo_oe, halt_r, ext_ie;
  always #25 clk_sys = ~clk_sys;
  mgp_ports #(.CRYSTAL_OPT(1'b0), .RC_OPT(1'b1)) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_hit(),
    .wake_pin_i(wake_pin_i), .wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe),
    .wake_pull_en(wake_pull_en), .mix_pin_i(mix_pin_i), .mix_pin_o(mix_pin_o),
    .mix_pin_oe(mix_pin_oe), .mix_pull_en(mix_pull_en), .out_port_o(out_port_o),
    .in_port_i(4'h0), .osc_clk(1'b0), .clock_input_hold(clock_input_hold),
    .crystal_clock_output(), .crystal_clock_output_oe(xo_oe), .halt_r(halt_r),
    .halt_restart(alt_in[0]), .multi_input_wakeup(wake_mw), .wake_levels(),
    .comparator_positive_input(cmp_in[1]), .comparator_negative_input(cmp_in[0]),
    .comparator_result(alt_in[1]), .modulator_value(alt_in[2]),
    .external_interrupt_pin(mix_alt[2]), .external_interrupt_en(ext_ie),
    .timer_pin_in(mix_alt[1]), .timer_out(alt_in[3]), .serial_data_in(mix_alt[0]),
    .serial_data_out(alt_in[4]), .serial_clock_out(alt_in[5]), .serial_clock_in());
  mgp_board board (
    .clk_sys(clk_sys), .wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe),
    .wake_pull_en(wake_pull_en), .mix_pin_o(mix_pin_o), .mix_pin_oe(mix_pin_oe),
    .mix_pull_en(mix_pull_en), .ext_w(ext_w), .ext_we(ext_we), .ext_m(ext_m),
    .ext_me(ext_me), .wake_pin_i(wake_pin_i), .mix_pin_i(mix_pin_i));
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1;
      `CHK(bus_rdata, e)
    end
  endtask
  task do_reset;
    begin
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1;
      `CHK(out_port_o, 4'hF)
      `CHK({wake_pin_oe, wake_pull_en, mix_pin_oe, halt_r}, 23'h00_0000)
    end
  endtask
  task give_verdict;
    begin
      if (fails == 0 && compares > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  initial begin
    do_reset;
    wr(8'hD1, 8'hCC);
    wr(8'hD0, 8'hAA);
    `CHK({wake_pin_oe, wake_pull_en, wake_pin_o & wake_pin_oe}, 24'hCC_2288)
    rd(8'hD1, 8'hCC);
    rd(8'hD0, 8'hAA);
    wr(8'hD5, 8'hFF);
    wr(8'hD4, 8'h15);
    `CHK({mix_pin_oe, mix_pin_o, halt_r}, 13'h1FAA)
    rd(8'hD5, 8'h3F);
    rd(8'hD4, 8'h15);
    wr(8'hD1, 8'h00);
    wr(8'hD5, 8'h00);
    // Levels held for many cycles so every edge is seen
    ext_w <= 8'h5A;
    ext_we <= 8'hFF;
    ext_m <= 8'hC9;
    ext_me <= 8'hFF;
    wr(8'hD2, 8'hFF);
    rd(8'hD2, 8'h5A);
    rd(8'hD6, 8'hC9);
    `CHK({mix_alt, cmp_in, wake_pin_oe}, 13'h1D00)
    ext_we <= 8'h0F;
    wr(8'hD0, 8'hF0);
    // Pull-ups reach the pins only after the write; let the synchroniser catch up
    repeat (2) @(posedge clk_sys);
    rd(8'hD2, 8'hFA);
    wr(8'hC9, 8'h0F);
    `CHK(wake_mw, 8'h0A)
    wr(8'hEF, 8'h01);
    `CHK(ext_ie, 1'b1)
    alt_in <= 6'h1A;
    wr(8'hEE, 8'h07);
    `CHK({mix_pin_oe[5:3], mix_pin_o[5:3]}, 6'h3B)
    wr(8'hCC, 8'h07);
    `CHK({wake_pin_oe[7], wake_pin_oe[0], wake_pin_o[7], wake_pin_o[0]}, 4'hD)
    wr(8'hD4, 8'h95);
    `CHK({halt_r, clock_input_hold, xo_oe}, 3'h6)
    wr(8'hD4, 8'h15);
    `CHK(halt_r, 1'b1)
    alt_in[0] <= 1'b1;
    @(posedge clk_sys);
    alt_in[0] <= 1'b0;
    #1;
    `CHK({halt_r, clock_input_hold}, 2'h0)
    wr(8'hDC, 8'h05);
    `CHK(out_port_o, 4'h5)
    rd(8'hD3, 8'h00);
    // Mid-run reset must undo every latch and alternate; halt is already cleared by the restart pulse above
    do_reset;
    give_verdict;
  end
endmodule // mgp_ports_test
